// File: src/laser_ctrl_defs.svh
// Timing counts and reset values for the laser remote control logic.
`ifndef LASER_CTRL_DEFS_SVH
`define LASER_CTRL_DEFS_SVH
`define CLK_PERIOD_NS       50
`define FILTER_CYCLES       4
`define ALARM_CLEAR_TIME_US 1000
`define ALARM_CLEAR_CYCLES  ((`ALARM_CLEAR_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_CYCLES      16
`define PROG_NUM_BITS       7
`define PROG_NUM_IDLE       7'h00
`define ALARM_RST_VAL       1'b1
`endif

// File: src/laser_ctrl_pkg.sv
// Types shared by the laser remote control logic.
`default_nettype none
package laser_ctrl_pkg;
  // Key switch position.
  typedef enum logic [1:0] {KEY_OFF, KEY_ON, KEY_REMOTE} key_pos_t;
  // Hard-wired command inputs from the machine controller.
  typedef struct packed {
    logic       laserRequest;
    logic       programExecute;
    logic       internalControl;
    logic       alarmClear;
    logic       guideLaser;
    logic       analogSelect;
    logic       programStop;
    logic [6:0] programNumber;
    logic       drivePower;
  } hardwire_in_t;
  // Power-source selection for the laser setpoint.
  typedef enum logic [1:0] {PWR_PROGRAM, PWR_ANALOG, PWR_SOFTWARE} pwr_src_t;
endpackage : laser_ctrl_pkg
`default_nettype wire

// File: src/laser_remote_control.sv
// Hard-wired remote control logic of the laser source.
// Operation
// - Key on with external control: emission follows modulation input only.
// - Key remote: emission needs modulation and program run, or run alone.
// - Drive emission indication and main-power-on indication outputs.
// - Remote main-power input on safety connector switches main power on.
// - Board-powered relay closes once main control board is up.
// - Other hard-wired commands ignored unless laser request is asserted; analog select and program zero still set the power source.
// - Execute rising edge starts program chosen by seven select bits.
// - Program zero and analog select high: power from analog value.
// - Program zero and analog select low: power from internal software.
// - Program zero, analog low, internal high: software controls emission.
// - Internal-control input high enables internal software mode.
// - Alarm-clear held high at least 1 ms clears latched alarm.
// - Guide laser on while guide input is asserted.
// - Analog select honoured only when program number is zero.
// - Stop input high aborts running program at once.
// - Lowest select line is program number LSB, six lines above.
// - Drive power on at rising edge, off at falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "laser_ctrl_defs.svh"
module laser_remote_control #(
  parameter bit          PROG_ONLY_VARIANT = 1'b0,
  parameter int unsigned CLEAR_CYCLES      = `ALARM_CLEAR_CYCLES
) (
  input  wire logic                         clk,           // 20 MHz clock.
  input  wire logic                         sys_rst,       // Sync reset.
  input  wire laser_ctrl_pkg::key_pos_t     keyPos,        // Key switch.
  input  wire logic                         externalMode,  // External ctrl.
  input  wire logic                         modulation,    // Modulation in.
  input  wire laser_ctrl_pkg::hardwire_in_t hw,            // Hard-wire in.
  input  wire logic                         remoteMainPwr, // Safety conn.
  input  wire logic                         boardPwrContact, // Board power.
  input  wire logic                         faultDetect,   // Alarm source.
  output var  logic                         emissionOn,    // Emission.
  output var  logic                         emissionInd,   // Emission ind.
  output var  logic                         mainPowerInd,  // Main power ind.
  output var  logic                         boardUpRelay,  // Board relay.
  output var  logic                         guideLaserOn,  // Guide laser.
  output var  logic                         programRun,    // Program active.
  output var  logic [6:0]                   programSel,    // Program number.
  output var  laser_ctrl_pkg::pwr_src_t     powerSource,   // Power source.
  output var  logic                         softwareMode,  // Software mode.
  output var  logic                         softwareEmit,  // Software emits.
  output var  logic                         laserAlarm     // Latched alarm.
);
  import laser_ctrl_pkg::*;
  localparam int NIN = $bits(hardwire_in_t) + 2;
  localparam int CW  = $clog2(CLEAR_CYCLES + 1);

  // ==========================================================================
  // Input conditioning
  // Two-stage synchroniser then a small agreement filter per bit; a glitch
  // shorter than the filter window never reaches the edge detectors.
  logic [NIN-1:0] rawIn;
  logic [NIN-1:0] sync1_q, sync2_q, filt_q, filt_d;
  assign rawIn = {hw, modulation, remoteMainPwr};
  // Synchroniser stages.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
    end
  end

  generate
    for (genvar gi = 0; gi < NIN; gi++) begin : g_filt
      logic [2:0] cnt_q, cnt_d;
      // Next filter count and output for one bit.
      always_comb begin
        cnt_d     = cnt_q;
        filt_d[gi] = filt_q[gi];
        if (sync2_q[gi] == filt_q[gi]) begin
          cnt_d = '0;
        end else if (cnt_q == 3'(`FILTER_CYCLES - 1)) begin
          cnt_d      = '0;
          filt_d[gi] = sync2_q[gi];
        end else begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      // Filter count register.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_d;
        end
      end
    end
  endgenerate
  // Filtered outputs and the previous copy for edges.
  logic [NIN-1:0] prev_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      filt_q <= '0;
      prev_q <= '0;
    end else begin
      filt_q <= filt_d;
      prev_q <= filt_q;
    end
  end

  hardwire_in_t f, fp;
  logic         fMod, fMainPwr;
  assign {f, fMod, fMainPwr} = filt_q;
  assign fp = prev_q[NIN-1:2];

  // ==========================================================================
  // Control state
  logic       req;
  logic       execRise, driveRise, driveFall, progZero;
  logic [6:0] progNum;
  assign req       = f.laserRequest;
  assign execRise  = req && f.programExecute && !fp.programExecute;
  assign driveRise = f.drivePower && !fp.drivePower;
  assign driveFall = !f.drivePower && fp.drivePower;
  // Bit 0 is the lowest select line; the six upper lines follow.
  assign progNum   = f.programNumber;
  assign progZero  = (progNum == `PROG_NUM_IDLE);
  logic           run_q, run_d, drv_q, drv_d, alarm_q, alarm_d;
  logic [6:0]     sel_q, sel_d;
  logic [CW-1:0]  clr_q, clr_d;
  logic [4:0]     boot_q, boot_d;
  logic           bootDone;
  assign bootDone = (boot_q == 5'(`POWERUP_CYCLES));
  // Next values of program, drive power, alarm and timers.
  always_comb begin
    run_d   = run_q;
    sel_d   = sel_q;
    drv_d   = drv_q;
    alarm_d = alarm_q;
    clr_d   = clr_q;
    boot_d  = bootDone ? boot_q : boot_q + 5'h1;
    if (req && f.programStop) begin
      run_d = 1'b0;
    end else if (execRise) begin
      run_d = 1'b1;
      sel_d = progNum;
    end
    if (req && driveRise) begin
      drv_d = 1'b1;
    end else if (req && driveFall) begin
      drv_d = 1'b0;
    end
    // A clear only counts once it has stood for the full minimum width.
    if (req && f.alarmClear) begin
      if (clr_q != CW'(CLEAR_CYCLES)) begin
        clr_d = clr_q + CW'(1);
      end
    end else begin
      clr_d = '0;
    end
    if (clr_q == CW'(CLEAR_CYCLES - 1) && req && f.alarmClear
        && bootDone) begin
      alarm_d = 1'b0;
    end
    // A fault in the clearing cycle wins, so no event is lost.
    if (faultDetect) begin
      alarm_d = 1'b1;
    end
  end

  // Control state registers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_q   <= 1'b0;
      sel_q   <= `PROG_NUM_IDLE;
      drv_q   <= 1'b0;
      alarm_q <= `ALARM_RST_VAL;
      clr_q   <= '0;
      boot_q  <= '0;
    end else begin
      run_q   <= run_d;
      sel_q   <= sel_d;
      drv_q   <= drv_d;
      alarm_q <= alarm_d;
      clr_q   <= clr_d;
      boot_q  <= boot_d;
    end
  end

  // ==========================================================================
  // Outputs
  logic     emit, mainOn, swMode, swEmit, boardUp;
  pwr_src_t src;
  // The board powers only with the key at remote and contact closed.
  assign boardUp = (keyPos == KEY_REMOTE) && boardPwrContact;
  assign mainOn  = fMainPwr || drv_q;
  assign swMode  = req && f.internalControl;
  assign swEmit  = progZero && !f.analogSelect && swMode;
  // Emission gating and power source selection.
  always_comb begin
    emit = 1'b0;
    src  = PWR_PROGRAM;
    if (externalMode && keyPos == KEY_ON) begin
      emit = fMod;
    end else if (externalMode && keyPos == KEY_REMOTE) begin
      emit = PROG_ONLY_VARIANT ? run_q : (fMod && run_q);
    end
    if (progZero) begin
      src = f.analogSelect ? PWR_ANALOG : PWR_SOFTWARE;
    end
  end

  // Output flip-flops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      emissionOn   <= 1'b0;
      emissionInd  <= 1'b0;
      mainPowerInd <= 1'b0;
      boardUpRelay <= 1'b0;
      guideLaserOn <= 1'b0;
      programRun   <= 1'b0;
      programSel   <= `PROG_NUM_IDLE;
      powerSource  <= PWR_PROGRAM;
      softwareMode <= 1'b0;
      softwareEmit <= 1'b0;
      laserAlarm   <= `ALARM_RST_VAL;
    end else begin
      emissionOn   <= emit && mainOn && !alarm_q;
      emissionInd  <= emit && mainOn && !alarm_q;
      mainPowerInd <= mainOn;
      boardUpRelay <= boardUp;
      guideLaserOn <= req && f.guideLaser;
      programRun   <= run_q;
      programSel   <= sel_q;
      powerSource  <= src;
      softwareMode <= swMode;
      softwareEmit <= swEmit;
      laserAlarm   <= alarm_q;
    end
  end

  // ==========================================================================
  // Assertions
  // All checks share the one clock and stay quiet while reset is held.
  default clocking cbCheck @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_stop_aborts;
    (req && f.programStop) |=> !run_q ##1 !programRun;
  endproperty
  a_stop_aborts: assert property (p_stop_aborts) else $error("stop");
  property p_exec_start;
    (execRise && !f.programStop) |=> run_q && sel_q == $past(progNum);
  endproperty
  a_exec_start: assert property (p_exec_start) else $error("start");
  property p_no_req;
    !req |=> run_q == $past(run_q) && drv_q == $past(drv_q) && !guideLaserOn;
  endproperty
  a_no_req: assert property (p_no_req) else $error("no request");
  property p_alarm_hold;
    (alarm_q && clr_q == '0) |=> alarm_q;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("hold");
  property p_clear;
    (!alarm_q && $past(alarm_q)) |-> $past(clr_q) == CW'(CLEAR_CYCLES - 1);
  endproperty
  a_clear: assert property (p_clear) else $error("short clear");
  property p_key_on;
    (externalMode && keyPos == KEY_ON && mainOn && !alarm_q)
      |=> emissionOn == $past(fMod);
  endproperty
  a_key_on: assert property (p_key_on) else $error("mod gating");
  property p_key_rem;
    (externalMode && keyPos == KEY_REMOTE && !run_q) |=> !emissionOn;
  endproperty
  a_key_rem: assert property (p_key_rem) else $error("remote");
  property p_ind;
    (emissionInd == emissionOn) && (!emissionOn || mainPowerInd);
  endproperty
  a_ind: assert property (p_ind) else $error("indication");
  property p_guide;
    (req && f.guideLaser) [*2] |-> guideLaserOn;
  endproperty
  a_guide: assert property (p_guide) else $error("guide");
  property p_src;
    !progZero |=> powerSource == PWR_PROGRAM;
  endproperty
  a_src: assert property (p_src) else $error("analog select");
  // Main scenarios: program start, alarm clear and emission switching on.
  c_start: cover property (execRise);
  c_clear: cover property ($fell(alarm_q));
  c_emit: cover property ($rose(emissionOn));
endmodule : laser_remote_control
`default_nettype wire

// File: testbench/machine_ctrl_model.sv
// Machine controller model driving the hard-wired control lines.
`timescale 1ns/1ps
`default_nettype none
module machine_ctrl_model #(
  parameter int unsigned HOLD = 16
) (
  input  wire logic                         clk,       // Bench clock.
  input  wire laser_ctrl_pkg::key_pos_t     keyPos,    // Key switch.
  input  wire laser_ctrl_pkg::hardwire_in_t cmd,       // Wanted levels.
  input  wire logic                         clearReq,  // Clear request.
  output var  laser_ctrl_pkg::hardwire_in_t hw,        // Lines driven.
  output var  logic                         contactOn  // Board contact.
);
  import laser_ctrl_pkg::*;
  logic [7:0] holdCnt_q = 8'h00;
  // A clear request is stretched so the pulse never falls short.
  always @(posedge clk) begin
    if (clearReq && holdCnt_q == 8'h00) begin
      holdCnt_q <= 8'(HOLD);
    end else if (holdCnt_q != 8'h00) begin
      holdCnt_q <= holdCnt_q - 8'h01;
    end
  end
  // All other lines pass through exactly as the bench set them.
  always_comb begin
    hw            = cmd;
    hw.alarmClear = (holdCnt_q != 8'h00);
  end
  // The contact closes whenever the key sits at remote.
  assign contactOn = (keyPos == KEY_REMOTE);
endmodule : machine_ctrl_model
`default_nettype wire

// File: testbench/tb_laser_remote_control.sv
// Self-checking bench for the laser remote control logic.
`timescale 1ns/1ps
`default_nettype none
module tb_laser_remote_control;
  import laser_ctrl_pkg::*;
  localparam int unsigned CLR = 8;
  logic         clk = 1'b0;
  logic         sysRst = 1'b1;
  key_pos_t     keyPos = KEY_OFF;
  logic         extMode = 1'b0, modIn = 1'b0, mainReq = 1'b0;
  logic         fault = 1'b0, clearReq = 1'b0, contact;
  hardwire_in_t cmd = '0;
  hardwire_in_t hw;
  logic         emitOn, emitInd, mainInd, relay, guideOn;
  logic         progRun, swMode, swEmit, alarm;
  logic [6:0]   progSel;
  pwr_src_t     pwrSrc;
  int           mismatches = 0;
  int           checkCount = 0;
  // Free-running 20 MHz clock.
  always #25 clk = ~clk;
  machine_ctrl_model #(.HOLD(CLR + 8)) pm (.clk(clk), .keyPos(keyPos),
    .cmd(cmd), .clearReq(clearReq), .hw(hw), .contactOn(contact));
  laser_remote_control #(.PROG_ONLY_VARIANT(1'b0), .CLEAR_CYCLES(CLR)) uut (
    .clk(clk), .sys_rst(sysRst), .keyPos(keyPos), .externalMode(extMode),
    .modulation(modIn), .hw(hw), .remoteMainPwr(mainReq),
    .boardPwrContact(contact), .faultDetect(fault), .emissionOn(emitOn),
    .emissionInd(emitInd), .mainPowerInd(mainInd), .boardUpRelay(relay),
    .guideLaserOn(guideOn), .programRun(progRun), .programSel(progSel),
    .powerSource(pwrSrc), .softwareMode(swMode), .softwareEmit(swEmit),
    .laserAlarm(alarm));
  // Compare one result against its expected value.
  task automatic chk(input string what, input logic [7:0] exp, got);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Inputs always move 1 ns after the edge, away from sampling.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Twelve cycles cover sync, filter, state and output stages.
  task automatic execEdge(input logic [6:0] num);
    cmd.programNumber = num;
    cmd.programExecute = 1'b1;
    cyc(12);
  endtask : execEdge
  task automatic stopProg();
    cmd.programStop = 1'b1;
    cmd.programExecute = 1'b0;
    cyc(12);
    cmd.programStop = 1'b0;
    cyc(12);
  endtask : stopProg
  task automatic testReset();
    chk("alarm", 8'h01, alarm);
    chk("emit", 8'h00, emitOn);
    chk("run", 8'h00, progRun);
    $display("test reset done");
  endtask : testReset
  // A clear without request is ignored; a fault re-arms the alarm.
  task automatic testAlarm();
    clearReq = 1'b1;
    cmd.programExecute = 1'b1;
    cyc(1);
    clearReq = 1'b0;
    cyc(30);
    chk("alarm", 8'h01, alarm);
    chk("run", 8'h00, progRun);
    cmd.programExecute = 1'b0;
    cmd.laserRequest = 1'b1;
    cyc(12);
    clearReq = 1'b1;
    cyc(1);
    clearReq = 1'b0;
    cyc(30);
    chk("alarm", 8'h00, alarm);
    fault = 1'b1;
    cyc(1);
    fault = 1'b0;
    cyc(4);
    chk("alarm", 8'h01, alarm);
    clearReq = 1'b1;
    cyc(1);
    clearReq = 1'b0;
    cyc(30);
    chk("alarm", 8'h00, alarm);
    $display("test alarm done");
  endtask : testAlarm
  // One-cycle glitch must not start; a real edge does; stop aborts.
  task automatic testProgram();
    keyPos = KEY_REMOTE;
    extMode = 1'b1;
    cmd.programNumber = 7'h41;
    cmd.programExecute = 1'b1;
    cyc(1);
    cmd.programExecute = 1'b0;
    cyc(12);
    chk("run", 8'h00, progRun);
    execEdge(7'h41);
    chk("run", 8'h01, progRun);
    chk("sel", 8'h41, {1'b0, progSel});
    stopProg();
    chk("run", 8'h00, progRun);
    $display("test program done");
  endtask : testProgram
  // Table of program number, analog and internal selections.
  task automatic testPower();
    logic [6:0] num [3] = '{7'h00, 7'h00, 7'h05};
    logic       ana [3] = '{1'b1, 1'b0, 1'b1};
    logic       itl [3] = '{1'b0, 1'b1, 1'b0};
    pwr_src_t   src [3] = '{PWR_ANALOG, PWR_SOFTWARE, PWR_PROGRAM};
    for (int i = 0; i < 3; i++) begin
      cmd.analogSelect = ana[i];
      cmd.internalControl = itl[i];
      execEdge(num[i]);
      chk("src", 8'(src[i]), 8'(pwrSrc));
      chk("swmode", 8'(itl[i]), swMode);
      chk("swemit", 8'(itl[i]), swEmit);
      stopProg();
    end
    cmd.internalControl = 1'b0;
    $display("test power done");
  endtask : testPower
  // Main power, relay, emission gating per key, drive power, guide.
  task automatic testEmission();
    mainReq = 1'b1;
    modIn = 1'b1;
    cyc(12);
    chk("main", 8'h01, mainInd);
    chk("relay", 8'h01, relay);
    chk("emit", 8'h00, emitOn);
    execEdge(7'h03);
    chk("emit", 8'h01, emitOn);
    chk("ind", 8'h01, emitInd);
    stopProg();
    keyPos = KEY_ON;
    cyc(12);
    chk("relay", 8'h00, relay);
    chk("emit", 8'h01, emitOn);
    extMode = 1'b0;
    cyc(2);
    chk("emit", 8'h00, emitOn);
    extMode = 1'b1;
    modIn = 1'b0;
    cyc(12);
    chk("emit", 8'h00, emitOn);
    mainReq = 1'b0;
    cmd.drivePower = 1'b1;
    cyc(12);
    chk("main", 8'h01, mainInd);
    cmd.drivePower = 1'b0;
    cmd.guideLaser = 1'b1;
    cyc(12);
    chk("main", 8'h00, mainInd);
    chk("guide", 8'h01, guideOn);
    cmd.guideLaser = 1'b0;
    cyc(12);
    chk("guide", 8'h00, guideOn);
    $display("test emission done");
  endtask : testEmission
  // Single place where the run ends.
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stopTest
  // Main sequence; reset is held 20 cycles, then the power-up wait.
  initial begin
    cyc(20);
    sysRst = 1'b0;
    cyc(20);
    testReset();
    testAlarm();
    testProgram();
    testPower();
    testEmission();
    stopTest();
  end
  // The tests take under 1000 cycles; this cuts a hang short.
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    stopTest();
  end
endmodule : tb_laser_remote_control
`default_nettype wire
